// ### elc_cpu_model.sv
// Processor-side model: counts event pulses and notes wakeup requests.
// Assumes one-cycle registered event pulses on pclk.
`timescale 1ns/1ps
module elc_cpu_model
  import elc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From controller
  input wire logic [ELC_LINES-1:0] line_event,
  input wire logic wakeup_req,
  // To bench
  output logic [15:0] ev_cnt,
  output logic woke
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_cnt <= 16'h0000;
      woke <= 1'b0;
    end else begin
      ev_cnt <= ev_cnt + 16'($countones(line_event));
      woke <= woke | wakeup_req;
    end
  end
endmodule

// ### elc_edge_det.sv
// Two-flop synchroniser and edge detector for one line.
// Assumes the input is a level from any domain.
`timescale 1ns/1ps
module elc_edge_det (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line
  input wire logic line_in,
  output logic rise_p,
  output logic fall_p
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } elc_det_t;
  elc_det_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = line_in;
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // One-cycle pulses from current versus previous sample
  assign rise_p = st_q.s2 & ~st_q.prev;
  assign fall_p = ~st_q.s2 & st_q.prev;
endmodule

// ### elc_pkg.sv
// Package of the external line controller: register map, widths, resets.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package elc_pkg;
  localparam int ELC_LINES = 25;
  localparam int ELC_PINS = 16;
  localparam int ELC_PORTS = 6;
  localparam int ELC_SEL_W = 3;
  localparam int ELC_ADDR_W = 12;
  localparam logic [11:0] ELC_OFF_INTEN = 12'h000;
  localparam logic [11:0] ELC_OFF_EVEN = 12'h004;
  localparam logic [11:0] ELC_OFF_RTEN = 12'h008;
  localparam logic [11:0] ELC_OFF_FTEN = 12'h00C;
  localparam logic [11:0] ELC_OFF_SWTRG = 12'h010;
  localparam logic [11:0] ELC_OFF_PEND = 12'h014;
  localparam logic [11:0] ELC_OFF_SRC_LO = 12'h018;
  localparam logic [11:0] ELC_OFF_SRC_HI = 12'h01C;
  localparam logic [24:0] ELC_EN_RST = 25'h0000000;
  localparam logic [47:0] ELC_SRC_RST = 48'h000000000000;
  localparam logic [2:0] ELC_PORT_F = 3'h5;
  localparam int ELC_FIRST_NARROW = 8;
  localparam logic [31:0] ELC_ZERO = 32'h00000000;
endpackage

// ### elc_props.sv
// Checker of bus timing and output relations of the line controller.
// Assumes it is bound to elc_top and sees only its ports.
`timescale 1ns/1ps
module elc_props
  import elc_pkg::*;
#(
  parameter int LINES = ELC_LINES
) (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ELC_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic [LINES-1:0] line_irq,
  input wire logic line_irq_any,
  input wire logic [LINES-1:0] line_event,
  input wire logic wakeup_req
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Aligned word inside the register map
  logic mapped;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ELC_OFF_SRC_HI);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> s_access)
    else $error("no answer one cycle after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_UNMAPPED: assert property (pready && !mapped
    |-> pslverr && prdata == ELC_ZERO) else $error("unmapped not refused");
  AST_MAPPED: assert property (pready && mapped
    |-> !pslverr) else $error("mapped access refused");
  AST_RESERVED: assert property (pready |-> prdata[31:25] == 7'h00)
    else $error("reserved bits read nonzero");
  AST_EVENT_PULSE: assert property ((line_event & $past(line_event)) == '0)
    else $error("event longer than one cycle");
  AST_IRQ_HOLD: assert property (|(~line_irq & $past(line_irq))
    |-> $past(psel & pwrite, 1) || $past(psel & pwrite, 2))
    else $error("interrupt dropped without a write");
  AST_ANY: assert property (line_irq_any == (|line_irq))
    else $error("summary interrupt differs from line interrupts");
  AST_WAKE: assert property (|line_irq |-> ##[0:1] wakeup_req)
    else $error("no wakeup while interrupt pending");
  AST_EVENT_WAKE: assert property ((|line_event) |-> wakeup_req)
    else $error("no wakeup with an event pulse");
endmodule
bind elc_top elc_props #(.LINES(LINES)) elc_props_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_irq(line_irq), .line_irq_any(line_irq_any),
  .line_event(line_event), .wakeup_req(wakeup_req));

// ### elc_top.sv
// External line controller: 25 edge detectors, APB registers,
// pending flags, interrupt, event and wakeup outputs.
// Assumes APB master on pclk and pin/peripheral lines as plain levels.
`timescale 1ns/1ps

// What this block does
// - Twenty-five independent line edge detectors
// - Rising, falling or both edges per line
// - Per-line configuration and masking, independent
// - Lines 0-15 from pins, rest internal
// - Pin line picks same index from port
// - Internal lines fixed to peripheral sources
// - Both enables set detect both transitions
// - Selected transition raises enabled interrupt/event
// - Interrupt sets pending flag; event does not
// - Software trigger acts like a hardware edge
// - Separate event outputs for event-enabled lines
// - Triggers of interrupt- or event-enabled lines forwarded to wakeup logic
// - Enable one enables, zero disables, reset zero
module elc_top
  import elc_pkg::*;
#(
  parameter int LINES = ELC_LINES
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ELC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin lines, one vector per port A..F
  input wire logic [ELC_PINS-1:0] port_a,
  input wire logic [ELC_PINS-1:0] port_b,
  input wire logic [ELC_PINS-1:0] port_c,
  input wire logic [ELC_PINS-1:0] port_d,
  input wire logic [ELC_PINS-1:0] port_e,
  input wire logic [ELC_PINS-1:0] port_f,
  // Internal peripheral lines
  input wire logic low_voltage_det,
  input wire logic rtc_alarm,
  input wire logic can0_wake,
  input wire logic can1_wake,
  input wire logic cmp_out,
  input wire logic uart0_wake,
  input wire logic uart1_wake,
  input wire logic uart2_wake,
  input wire logic over_voltage_det,
  // To processor and wakeup unit
  output logic [LINES-1:0] line_irq,
  output logic line_irq_any,
  output logic [LINES-1:0] line_event,
  output logic wakeup_req
);
  typedef struct packed {
    logic [LINES-1:0] int_en;
    logic [LINES-1:0] evt_en;
    logic [LINES-1:0] rise_en;
    logic [LINES-1:0] fall_en;
    logic [LINES-1:0] soft_trg;
    logic [LINES-1:0] pend;
    logic [47:0] src_sel;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [LINES-1:0] irq;
    logic irq_any;
    logic [LINES-1:0] evt;
    logic wake;
  } elc_state_t;

  elc_state_t st_q, st_d;
  logic [LINES-1:0] line_lvl;
  logic [LINES-1:0] rise_p;
  logic [LINES-1:0] fall_p;
  logic [LINES-1:0] hw_trg;
  logic [LINES-1:0] sw_trg;
  logic [LINES-1:0] trg;
  logic setup;
  logic wr;
  logic rd;
  logic hit;

  // Source select layout: two words of eight 3-bit port codes
  localparam int SRC_HALF = ELC_FIRST_NARROW * ELC_SEL_W;
  localparam logic [ELC_SEL_W-1:0] SEL_A = 3'h0;
  localparam logic [ELC_SEL_W-1:0] SEL_B = 3'h1;
  localparam logic [ELC_SEL_W-1:0] SEL_C = 3'h2;
  localparam logic [ELC_SEL_W-1:0] SEL_D = 3'h3;
  localparam logic [ELC_SEL_W-1:0] SEL_E = 3'h4;

  // Pin lines: per-line port selector, same pin index
  genvar g;
  generate
    for (g = 0; g < ELC_PINS; g++) begin : g_pin
      logic [ELC_SEL_W-1:0] sel;
      assign sel = st_q.src_sel[g*ELC_SEL_W +: ELC_SEL_W];
      always_comb begin
        case (sel)
          SEL_A: line_lvl[g] = port_a[g];
          SEL_B: line_lvl[g] = port_b[g];
          SEL_C: line_lvl[g] = port_c[g];
          SEL_D: line_lvl[g] = port_d[g];
          SEL_E: line_lvl[g] = port_e[g];
          // Port F has no pins on the upper eight lines
          ELC_PORT_F:
            line_lvl[g] = (g < ELC_FIRST_NARROW) ? port_f[g] : 1'b0;
          default: line_lvl[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Internal lines 16..24
  assign line_lvl[16] = low_voltage_det;
  assign line_lvl[17] = rtc_alarm;
  assign line_lvl[18] = can0_wake;
  assign line_lvl[19] = can1_wake;
  assign line_lvl[20] = cmp_out;
  assign line_lvl[21] = uart0_wake;
  assign line_lvl[22] = uart1_wake;
  assign line_lvl[23] = uart2_wake;
  assign line_lvl[24] = over_voltage_det;

  // One detector per line
  generate
    for (g = 0; g < LINES; g++) begin : g_det
      elc_edge_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(line_lvl[g]),
        .rise_p(rise_p[g]),
        .fall_p(fall_p[g])
      );
      // Each line gated by its own edge enables only
      assign hw_trg[g] = (rise_p[g] & st_q.rise_en[g]) |
                         (fall_p[g] & st_q.fall_en[g]);
    end
  endgenerate

  // APB decode; zero-wait, answer in the access cycle
  assign setup = psel & ~penable;
  assign wr = setup & pwrite;
  assign rd = setup & ~pwrite;
  always_comb begin
    case (paddr)
      ELC_OFF_INTEN, ELC_OFF_EVEN, ELC_OFF_RTEN, ELC_OFF_FTEN,
      ELC_OFF_SWTRG, ELC_OFF_PEND, ELC_OFF_SRC_LO, ELC_OFF_SRC_HI:
        hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Software trigger: rising edge of a written bit
  assign sw_trg = (wr && paddr == ELC_OFF_SWTRG) ?
                  (pwdata[LINES-1:0] & ~st_q.soft_trg) : '0;
  assign trg = hw_trg | sw_trg;

  always_comb begin
    st_d = st_q;
    st_d.ready = setup;
    st_d.err = setup & ~hit;
    st_d.rdata = ELC_ZERO;
    if (wr) begin
      case (paddr)
        ELC_OFF_INTEN: st_d.int_en = pwdata[LINES-1:0];
        ELC_OFF_EVEN: st_d.evt_en = pwdata[LINES-1:0];
        ELC_OFF_RTEN: st_d.rise_en = pwdata[LINES-1:0];
        ELC_OFF_FTEN: st_d.fall_en = pwdata[LINES-1:0];
        ELC_OFF_SWTRG: st_d.soft_trg = pwdata[LINES-1:0];
        // Write one to clear pending; also drops the soft trigger bit
        ELC_OFF_PEND: begin
          st_d.pend = st_q.pend & ~pwdata[LINES-1:0];
          st_d.soft_trg = st_q.soft_trg & ~pwdata[LINES-1:0];
        end
        ELC_OFF_SRC_LO:
          st_d.src_sel[0 +: SRC_HALF] = pwdata[SRC_HALF-1:0];
        ELC_OFF_SRC_HI:
          st_d.src_sel[SRC_HALF +: SRC_HALF] = pwdata[SRC_HALF-1:0];
        default: st_d.err = 1'b1;
      endcase
    end
    // New interrupt triggers win over a same-cycle clear
    st_d.pend = st_d.pend | (trg & st_q.int_en);
    if (rd) begin
      case (paddr)
        ELC_OFF_INTEN: st_d.rdata[LINES-1:0] = st_q.int_en;
        ELC_OFF_EVEN: st_d.rdata[LINES-1:0] = st_q.evt_en;
        ELC_OFF_RTEN: st_d.rdata[LINES-1:0] = st_q.rise_en;
        ELC_OFF_FTEN: st_d.rdata[LINES-1:0] = st_q.fall_en;
        ELC_OFF_SWTRG: st_d.rdata[LINES-1:0] = st_q.soft_trg;
        ELC_OFF_PEND: st_d.rdata[LINES-1:0] = st_q.pend;
        ELC_OFF_SRC_LO:
          st_d.rdata[SRC_HALF-1:0] = st_q.src_sel[0 +: SRC_HALF];
        ELC_OFF_SRC_HI:
          st_d.rdata[SRC_HALF-1:0] = st_q.src_sel[SRC_HALF +: SRC_HALF];
        default: st_d.rdata = ELC_ZERO;
      endcase
    end
    // Outputs, all registered
    st_d.irq = st_d.pend & st_q.int_en;
    st_d.irq_any = |(st_d.pend & st_q.int_en);
    st_d.evt = trg & st_q.evt_en;
    st_d.wake = |(trg & (st_q.int_en | st_q.evt_en)) |
                |(st_d.pend & st_q.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.int_en <= ELC_EN_RST;
      st_q.evt_en <= ELC_EN_RST;
      st_q.src_sel <= ELC_SRC_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign line_irq = st_q.irq;
  assign line_irq_any = st_q.irq_any;
  assign line_event = st_q.evt;
  assign wakeup_req = st_q.wake;
endmodule

// ### tb_external_line_edge_detector.sv
// Testbench of the line controller: table of line cases, then bus cases.
// Assumes elc_top, elc_cpu_model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_external_line_edge_detector
  import elc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rerr, irq_any, wake, woke, trig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, m;
  logic [24:0] lines, line_irq, line_event;
  logic [15:0] ev_cnt, c, pb, pf;
  logic [4:0] l;
  logic [5:0] f;
  // Line, then rise, fall, start level, irq en, event en, soft trigger
  logic [10:0] rows [8] = '{11'h0E6, 11'h0D6, 11'h25C, 11'h43A,
    11'h636, 11'h145, 11'h503, 11'h320};
  int n_errors = 0, tests_run = 0, cyc = 0, i, j;
  elc_top elc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a(lines[15:0]), .port_b(pb), .port_c(16'h0000),
    .port_d(16'h0000), .port_e(16'h0000), .port_f(pf),
    .low_voltage_det(lines[16]), .rtc_alarm(lines[17]),
    .can0_wake(lines[18]), .can1_wake(lines[19]), .cmp_out(lines[20]),
    .uart0_wake(lines[21]), .uart1_wake(lines[22]),
    .uart2_wake(lines[23]), .over_voltage_det(lines[24]),
    .line_irq(line_irq), .line_irq_any(irq_any),
    .line_event(line_event), .wakeup_req(wake));
  elc_cpu_model elc_cpu_model_inst (.pclk(pclk), .presetn(presetn),
    .line_event(line_event), .wakeup_req(wake), .ev_cnt(ev_cnt),
    .woke(woke));
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task print_verdict;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = ELC_ZERO;
    lines = 25'h0000000;
    pb = 16'h0000;
    pf = 16'h0000;
    repeat (12) @(posedge pclk);
    `CHK({line_irq, line_event, irq_any}, 51'h0)
    presetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      {l, f} = rows[i];
      lines[l] <= f[3];
      repeat (6) @(posedge pclk);
      m = 32'h1 << l;
      apb(1'b1, ELC_OFF_PEND, 32'hFFFFFFFF);
      apb(1'b1, ELC_OFF_RTEN, f[5] ? m : ELC_ZERO);
      apb(1'b1, ELC_OFF_FTEN, f[4] ? m : ELC_ZERO);
      apb(1'b1, ELC_OFF_INTEN, f[2] ? m : ELC_ZERO);
      apb(1'b1, ELC_OFF_EVEN, f[1] ? m : ELC_ZERO);
      c = ev_cnt;
      trig = f[0] | (f[3] ? f[4] : f[5]);
      if (f[0]) apb(1'b1, ELC_OFF_SWTRG, m);
      else lines[l] <= ~f[3];
      repeat (8) @(posedge pclk);
      apb(1'b0, ELC_OFF_PEND, ELC_ZERO);
      `CHK(rdat, (trig & f[2]) ? m : ELC_ZERO)
      `CHK(line_irq, (trig & f[2]) ? m[24:0] : 25'h0000000)
      `CHK(irq_any, trig & f[2])
      `CHK(wake, trig & f[2])
      `CHK(ev_cnt - c, {15'h0000, trig & f[1]})
      for (j = 0; j < 5; j++) apb(1'b1, 12'(j * 4), ELC_ZERO);
      apb(1'b1, ELC_OFF_PEND, 32'hFFFFFFFF);
    end
    // Line 2 from port B, line 9 from port F (no such pin)
    apb(1'b1, ELC_OFF_SRC_LO, 32'h00000040);
    apb(1'b1, ELC_OFF_SRC_HI, 32'h00000028);
    apb(1'b0, ELC_OFF_SRC_LO, ELC_ZERO);
    `CHK(rdat, 32'h00000040)
    apb(1'b1, ELC_OFF_RTEN, 32'h00000204);
    apb(1'b1, ELC_OFF_INTEN, 32'h00000204);
    lines[2] <= 1'b1;
    pf[9] <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, ELC_OFF_PEND, ELC_ZERO);
    `CHK(rdat, ELC_ZERO)
    pb[2] <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, ELC_OFF_PEND, ELC_ZERO);
    `CHK(rdat, 32'h00000004)
    `CHK(wake, 1'b1)
    apb(1'b1, ELC_OFF_PEND, 32'h00000004);
    `CHK(line_irq, 25'h0000000)
    apb(1'b1, ELC_OFF_EVEN, 32'hFFFFFFFF);
    apb(1'b0, ELC_OFF_EVEN, ELC_ZERO);
    `CHK(rdat, 32'h01FFFFFF)
    apb(1'b0, 12'h020, ELC_ZERO);
    `CHK({rerr, rdat}, 33'h100000000)
    `CHK(woke, 1'b1)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(woke, 1'b0)
    presetn <= 1'b1;
    repeat (2) begin
      @(posedge pclk);
      `CHK({line_irq, line_event, irq_any, wake, pready}, 53'h0)
    end
    apb(1'b0, ELC_OFF_EVEN, ELC_ZERO);
    `CHK(rdat, ELC_ZERO)
    print_verdict;
  end
endmodule
